// file: rtl/lsd_regs.svh
// Purpose: Register offsets, field positions, reset values and settings.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes:   Definitions only.
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH
`define LSD_ADR_CTRL   8'h00
`define LSD_ADR_VTHR   8'h04
`define LSD_ADR_ITHR   8'h08
`define LSD_ADR_VNOM   8'h0C
`define LSD_ADR_INOM   8'h10
`define LSD_ADR_STAT   8'h14
`define LSD_ADR_MAG0   8'h20
`define LSD_ADR_MAG5   8'h34
`define LSD_CTRL_EN    0
`define LSD_VTHR_MIN   7'h0A
`define LSD_VTHR_MAX   7'h64
`define LSD_VTHR_DEF   7'h3C
`define LSD_ITHR_MIN   7'h02
`define LSD_ITHR_MAX   7'h64
`define LSD_ITHR_DEF   7'h0A
`define LSD_PCT_FULL   7'h64
`define LSD_NOM_DEF    16'h4000
`define LSD_FOUR_LAST  4'hF
`define LSD_FOUR_SHIFT 17
`endif

// file: rtl/lsd_pkg.sv
// Purpose: Shared types of the line state detector.
// Assumes: Nothing beyond the register header.
// Notes:   States carry no explicit codes.
package lsd_pkg;
  typedef enum logic {LSD_WB_IDLE, LSD_WB_ACK} lsd_wb_e;
  typedef logic [15:0] lsd_mag_t;
  typedef logic [6:0]  lsd_pct_t;
endpackage

// file: rtl/lsd_fourier.sv
// Purpose: Fundamental magnitude of one sampled channel over 16 samples.
// Assumes: Sixteen samples per fundamental period, one per sample strobe.
// Notes:   Magnitude uses max plus half min, within about 12 percent.
`timescale 1ns/1ps
`include "lsd_regs.svh"
module lsd_fourier (
  input  wire logic                clk,      // Block clock.
  input  wire logic                rst_n,    // Asynchronous reset, low.
  input  wire logic                smp_stb,  // One pulse per sample.
  input  wire logic signed [15:0]  smp,      // Sampled value.
  output lsd_pkg::lsd_mag_t        mag       // Fundamental amplitude.
);
  logic        [3:0]  idx_r;
  logic signed [35:0] re_r;
  logic signed [35:0] im_r;
  logic signed [35:0] re_nxt;
  logic signed [35:0] im_nxt;
  logic        [35:0] are;
  logic        [35:0] aim;
  logic        [35:0] big;
  logic        [35:0] amp;
  lsd_pkg::lsd_mag_t  mag_r;

  // Returns the cosine of 2*pi*k/16 scaled by 16384.
  function automatic logic signed [15:0] cos_q(input logic [3:0] k);
    logic signed [15:0] v;
    case (k[2:0])
      3'h0: v = 16'sh4000;
      3'h1: v = 16'sh3B21;
      3'h2: v = 16'sh2D41;
      3'h3: v = 16'sh187E;
      3'h4: v = 16'sh0000;
      3'h5: v = -16'sh187E;
      3'h6: v = -16'sh2D41;
      default: v = -16'sh3B21;
    endcase
    return k[3] ? -v : v;
  endfunction

  // Correlates the sample with cosine and sine of the fundamental.
  always_comb
  begin
    re_nxt = re_r + 36'(smp * cos_q(idx_r));
    im_nxt = im_r + 36'(smp * cos_q(idx_r - 4'h4));
    are    = re_nxt[35] ? 36'(-re_nxt) : re_nxt;
    aim    = im_nxt[35] ? 36'(-im_nxt) : im_nxt;
    big    = (are > aim) ? are + (aim >> 1) : aim + (are >> 1);
    amp    = big >> `LSD_FOUR_SHIFT;
  end

  // Accumulates a window and latches its magnitude at the last sample.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_r <= 4'h0;
      re_r  <= 36'h0;
      im_r  <= 36'h0;
      mag_r <= 16'h0;
    end
    else if (smp_stb)
    begin
      idx_r <= idx_r + 4'h1;
      if (idx_r == `LSD_FOUR_LAST)
      begin
        re_r  <= 36'h0;
        im_r  <= 36'h0;
        mag_r <= (amp[35:16] != 20'h0) ? 16'hFFFF : amp[15:0];
      end
      else
      begin
        re_r <= re_nxt;
        im_r <= im_nxt;
      end
    end
  end

  assign mag = mag_r;
endmodule

// file: rtl/lsd_compare.sv
// Purpose: Percentage threshold comparison of six magnitudes.
// Assumes: Magnitudes and nominals share one scale per quantity.
// Notes:   Equal to the threshold counts as neither above nor below.
`timescale 1ns/1ps
`include "lsd_regs.svh"
module lsd_compare (
  input  wire logic                clk,       // Block clock.
  input  wire logic                rst_n,     // Asynchronous reset, low.
  input  lsd_pkg::lsd_mag_t        mag [6],   // Voltages 0..2, currents 3..5.
  input  lsd_pkg::lsd_pct_t        vthr,      // Voltage threshold percent.
  input  lsd_pkg::lsd_pct_t        ithr,      // Current threshold percent.
  input  lsd_pkg::lsd_mag_t        vnom,      // Nominal voltage magnitude.
  input  lsd_pkg::lsd_mag_t        inom,      // Nominal current magnitude.
  output logic               [5:0] over,      // Above threshold per channel.
  output logic                     dead_raw,  // All six below threshold.
  output logic                     live_raw   // All voltages above threshold.
);
  logic [5:0] over_c;
  logic [5:0] under_c;

  // Scales magnitude by 100 and threshold by nominal; returns the sign.
  function automatic logic [1:0] cmp(input lsd_pkg::lsd_mag_t m,
                                     input lsd_pkg::lsd_pct_t p,
                                     input lsd_pkg::lsd_mag_t n);
    logic [22:0] lhs;
    logic [22:0] rhs;
    lhs = m * `LSD_PCT_FULL;
    rhs = p * n;
    return {lhs > rhs, lhs < rhs};
  endfunction

  // Compares each channel against its own quantity's threshold.
  always_comb
  begin
    for (int c = 0; c < 6; c++)
    begin
      {over_c[c], under_c[c]} = (c < 3) ? cmp(mag[c], vthr, vnom)
                                        : cmp(mag[c], ithr, inom);
    end
  end

  // Registers the per-channel flags and the two line conditions.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      over     <= 6'h00;
      dead_raw <= 1'b0;
      live_raw <= 1'b0;
    end
    else
    begin
      over     <= over_c;
      dead_raw <= &under_c;
      live_raw <= &over_c[2:0];
    end
  end
endmodule

// file: rtl/lsd_top.sv
// Purpose: Line state detector: decides dead or live three-phase line.
// Assumes: Sample inputs are synchronous to MCLK; classic Wishbone slave.
// Notes:   All outputs are flip-flops; everything resets inactive.
//          No hysteresis and no operate delay are applied.
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "lsd_regs.svh"
module lsd_top (
  input  wire logic         MCLK,                    // Clock, 250 MHz.
  input  wire logic         RST_N,                   // Async reset, low.
  input  wire logic         WB_CYC_I,                // Bus cycle.
  input  wire logic         WB_STB_I,                // Bus strobe.
  input  wire logic         WB_WE_I,                 // Write enable.
  input  wire logic  [7:0]  WB_ADR_I,                // Byte address.
  input  wire logic  [3:0]  WB_SEL_I,                // Byte lanes.
  input  wire logic  [31:0] WB_DAT_I,                // Write data.
  output logic       [31:0] WB_DAT_O,                // Read data.
  output logic              WB_ACK_O,                // Acknowledge.
  input  wire logic         SMP_STB,                 // Sample strobe.
  input  wire logic  [15:0] SMP_VOLT1,               // Phase 1 voltage.
  input  wire logic  [15:0] SMP_VOLT2,               // Phase 2 voltage.
  input  wire logic  [15:0] SMP_VOLT3,               // Phase 3 voltage.
  input  wire logic  [15:0] SMP_CURR1,               // Phase 1 current.
  input  wire logic  [15:0] SMP_CURR2,               // Phase 2 current.
  input  wire logic  [15:0] SMP_CURR3,               // Phase 3 current.
  input  wire logic         FUNCTION_INHIBIT_IN,     // Block, high.
  output logic              PHASE1_VOLT_OVER_LIMIT,  // Phase 1 volt above.
  output logic              PHASE2_VOLT_OVER_LIMIT,  // Phase 2 volt above.
  output logic              PHASE3_VOLT_OVER_LIMIT,  // Phase 3 volt above.
  output logic              PHASE1_CURR_OVER_LIMIT,  // Phase 1 curr above.
  output logic              PHASE2_CURR_OVER_LIMIT,  // Phase 2 curr above.
  output logic              PHASE3_CURR_OVER_LIMIT,  // Phase 3 curr above.
  output logic              LINE_DEENERGISED,        // Dead line.
  output logic              LINE_LIVE                // Live line.
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Names ending in _r are flip-flops; mag, over, dead_raw and live_raw come from flip-flops in the submodules; the rest is combinational.
  lsd_pkg::lsd_wb_e   wb_state_r;
  logic               ack_r;
  logic        [31:0] dat_r;
  logic        [31:0] rd_data;
  logic               wr_now;
  logic               op_en_r;
  lsd_pkg::lsd_pct_t  vthr_r;
  lsd_pkg::lsd_pct_t  ithr_r;
  lsd_pkg::lsd_mag_t  vnom_r;
  lsd_pkg::lsd_mag_t  inom_r;
  logic signed [15:0] smp [6];
  lsd_pkg::lsd_mag_t  mag [6];
  logic         [5:0] over;
  logic               dead_raw;
  logic               live_raw;
  logic               active;
  logic         [5:0] flag_r;
  logic               dead_r;
  logic               live_r;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Clamps a percentage write into its legal setting range.
  // Only the low byte counts; higher bits are ignored.
  function automatic lsd_pkg::lsd_pct_t clamp_pct(input logic [7:0] v,
                                                  input logic [6:0] lo,
                                                  input logic [6:0] hi);
    lsd_pkg::lsd_pct_t r;
    if (v < {1'b0, lo})
    begin
      r = lo;
    end
    else if (v > {1'b0, hi})
    begin
      r = hi;
    end
    else
    begin
      r = v[6:0];
    end
    return r;
  endfunction

  // Merges the two low byte lanes of a write into a 16-bit value.
  // Lanes 2 and 3 carry nothing here.
  function automatic logic [15:0] lane16(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  sel);
    logic [15:0] r;
    r       = old;
    if (sel[0])
    begin
      r[7:0] = d[7:0];
    end
    if (sel[1])
    begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************

  // A write takes effect on the edge where the master sees ack high.
  // Register writes and the ack pulse thus share one edge.
  // Writing in the taking cycle would land one edge too early.
  assign wr_now = (wb_state_r == lsd_pkg::LSD_WB_ACK) && WB_CYC_I &&
                  WB_STB_I && WB_WE_I;

  // Read mux; unmapped addresses read as zero but are still acked.
  // Captured at the taking edge, one cycle before the ack.
  // Status therefore shows outputs one cycle old.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (WB_ADR_I)
      `LSD_ADR_CTRL: rd_data[`LSD_CTRL_EN] = op_en_r;
      `LSD_ADR_VTHR: rd_data[6:0]  = vthr_r;
      `LSD_ADR_ITHR: rd_data[6:0]  = ithr_r;
      `LSD_ADR_VNOM: rd_data[15:0] = vnom_r;
      `LSD_ADR_INOM: rd_data[15:0] = inom_r;
      `LSD_ADR_STAT: rd_data[9:0]  = {FUNCTION_INHIBIT_IN, active,
                                      flag_r, live_r, dead_r};
      default:
      begin
        if (WB_ADR_I >= `LSD_ADR_MAG0 && WB_ADR_I <= `LSD_ADR_MAG5 &&
            WB_ADR_I[1:0] == 2'h0)
        begin
          rd_data[15:0] = mag[3'(WB_ADR_I[4:2])];
        end
      end
    endcase
  end

  // Handshake: ack one cycle after the request, held for one cycle.
  // The ACK state ignores the bus, so ack is never two cycles long.
  // Read data stays on the bus until the next transfer is taken.
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wb_state_r <= lsd_pkg::LSD_WB_IDLE;
      ack_r      <= 1'b0;
      dat_r      <= 32'h0000_0000;
    end
    else
    begin
      case (wb_state_r)
        lsd_pkg::LSD_WB_IDLE:
        begin
          if (WB_CYC_I && WB_STB_I)
          begin
            wb_state_r <= lsd_pkg::LSD_WB_ACK;
            ack_r      <= 1'b1;
            dat_r      <= WB_WE_I ? 32'h0000_0000 : rd_data;
          end
        end
        lsd_pkg::LSD_WB_ACK:
        begin
          wb_state_r <= lsd_pkg::LSD_WB_IDLE;
          ack_r      <= 1'b0;
        end
        default:
        begin
          wb_state_r <= lsd_pkg::LSD_WB_IDLE;
          ack_r      <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Settings registers
  // ****************************************************************

  // Operation enable; off after reset so the function stays quiet.
  // A write without lane 0 leaves the bit as it was.
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      op_en_r <= 1'b0;
    end
    else if (wr_now && WB_ADR_I == `LSD_ADR_CTRL && WB_SEL_I[0])
    begin
      op_en_r <= WB_DAT_I[`LSD_CTRL_EN];
    end
  end

  // Percent thresholds; writes outside the range are clamped to it.
  // Clamping keeps a bad write from leaving a stale setting.
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      vthr_r <= `LSD_VTHR_DEF;
      ithr_r <= `LSD_ITHR_DEF;
    end
    else if (wr_now && WB_SEL_I[0])
    begin
      if (WB_ADR_I == `LSD_ADR_VTHR)
      begin
        vthr_r <= clamp_pct(WB_DAT_I[7:0], `LSD_VTHR_MIN,
                            `LSD_VTHR_MAX);
      end
      if (WB_ADR_I == `LSD_ADR_ITHR)
      begin
        ithr_r <= clamp_pct(WB_DAT_I[7:0], `LSD_ITHR_MIN,
                            `LSD_ITHR_MAX);
      end
    end
  end

  // Nominal magnitudes that the percentages refer to.
  // A zero nominal means nothing is ever below: no dead line.
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      vnom_r <= `LSD_NOM_DEF;
      inom_r <= `LSD_NOM_DEF;
    end
    else if (wr_now)
    begin
      if (WB_ADR_I == `LSD_ADR_VNOM)
      begin
        vnom_r <= lane16(vnom_r, WB_DAT_I, WB_SEL_I);
      end
      if (WB_ADR_I == `LSD_ADR_INOM)
      begin
        inom_r <= lane16(inom_r, WB_DAT_I, WB_SEL_I);
      end
    end
  end

  // ****************************************************************
  // Preparation stage
  // ****************************************************************

  // Channel order: voltages of phases 1 to 3, then currents.
  // Samples are used only on strobe cycles.
  assign smp[0] = SMP_VOLT1;
  assign smp[1] = SMP_VOLT2;
  assign smp[2] = SMP_VOLT3;
  assign smp[3] = SMP_CURR1;
  assign smp[4] = SMP_CURR2;
  assign smp[5] = SMP_CURR3;

  // One independent fundamental extractor per channel.
  // A shared strobe keeps the six windows aligned in time.
  for (genvar c = 0; c < 6; c++)
  begin : g_four
    lsd_fourier u_four (
      .clk     (MCLK),
      .rst_n   (RST_N),
      .smp_stb (SMP_STB),
      .smp     (smp[c]),
      .mag     (mag[c])
    );
  end

  // ****************************************************************
  // Comparison stage
  // ****************************************************************

  // Threshold comparisons on the six fundamentals.
  // Flags and line conditions leave it on one edge, so they agree.
  // Equal to a threshold counts as neither above nor below.
  lsd_compare u_cmp (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .mag      (mag),
    .vthr     (vthr_r),
    .ithr     (ithr_r),
    .vnom     (vnom_r),
    .inom     (inom_r),
    .over     (over),
    .dead_raw (dead_raw),
    .live_raw (live_raw)
  );

  // ****************************************************************
  // Decision stage
  // ****************************************************************

  // The function runs only when enabled and not inhibited.
  // The inhibit is a level, sampled at every edge.
  assign active = op_en_r && !FUNCTION_INHIBIT_IN;

  // Gates every internal result with the enable and the inhibit.
  // Gating reaches the pins one edge after enable or inhibit moves.
  // Results keep running while gated, so release shows fresh values.
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      flag_r <= 6'h00;
      dead_r <= 1'b0;
      live_r <= 1'b0;
    end
    else
    begin
      flag_r <= active ? over : 6'h00;
      dead_r <= active && dead_raw;
      live_r <= active && live_raw;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Every output is a flip-flop.
  // Voltage flags sit in bits 0 to 2, current flags in bits 3 to 5.
  assign WB_ACK_O               = ack_r;
  assign WB_DAT_O               = dat_r;
  assign PHASE1_VOLT_OVER_LIMIT = flag_r[0];
  assign PHASE2_VOLT_OVER_LIMIT = flag_r[1];
  assign PHASE3_VOLT_OVER_LIMIT = flag_r[2];
  assign PHASE1_CURR_OVER_LIMIT = flag_r[3];
  assign PHASE2_CURR_OVER_LIMIT = flag_r[4];
  assign PHASE3_CURR_OVER_LIMIT = flag_r[5];
  assign LINE_DEENERGISED       = dead_r;
  assign LINE_LIVE              = live_r;
endmodule

// file: sim/lsd_properties.sv
// Purpose: Port-level checks of the line state detector.
// Assumes: Classic single-cycle bus masters; one clock domain.
// Notes:   The enable bit is mirrored from acknowledged writes.
`timescale 1ns/1ps
`include "lsd_regs.svh"
module lsd_properties (
  input wire logic        MCLK,                    // Clock.
  input wire logic        RST_N,                   // Reset, low.
  input wire logic        WB_CYC_I,                // Bus cycle.
  input wire logic        WB_STB_I,                // Bus strobe.
  input wire logic        WB_WE_I,                 // Write enable.
  input wire logic [7:0]  WB_ADR_I,                // Byte address.
  input wire logic [3:0]  WB_SEL_I,                // Byte lanes.
  input wire logic [31:0] WB_DAT_I,                // Write data.
  input wire logic [31:0] WB_DAT_O,                // Read data.
  input wire logic        WB_ACK_O,                // Acknowledge.
  input wire logic        FUNCTION_INHIBIT_IN,     // Block input.
  input wire logic        PHASE1_VOLT_OVER_LIMIT,  // Flag.
  input wire logic        PHASE2_VOLT_OVER_LIMIT,  // Flag.
  input wire logic        PHASE3_VOLT_OVER_LIMIT,  // Flag.
  input wire logic        PHASE1_CURR_OVER_LIMIT,  // Flag.
  input wire logic        PHASE2_CURR_OVER_LIMIT,  // Flag.
  input wire logic        PHASE3_CURR_OVER_LIMIT,  // Flag.
  input wire logic        LINE_DEENERGISED,        // Dead line.
  input wire logic        LINE_LIVE                // Live line.
);
  // ************************************************
  // Helper logic and assertions
  // ************************************************
  logic [5:0] flg;
  logic [7:0] outs;
  logic       en_r;

  // Flags grouped voltages low, currents high.
  assign flg = {PHASE3_CURR_OVER_LIMIT, PHASE2_CURR_OVER_LIMIT, PHASE1_CURR_OVER_LIMIT,
                PHASE3_VOLT_OVER_LIMIT, PHASE2_VOLT_OVER_LIMIT, PHASE1_VOLT_OVER_LIMIT};
  assign outs = {LINE_LIVE, LINE_DEENERGISED, flg};

  // Enable mirror, updated at the edge where the write is acknowledged.
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N)
      en_r <= 1'b0;
    else if (WB_ACK_O && WB_WE_I && WB_ADR_I == `LSD_ADR_CTRL && WB_SEL_I[0])
      en_r <= WB_DAT_I[0];

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  dead_no_flag_a: assert property (LINE_DEENERGISED |-> flg == 6'h00)
    else $error("dead line with a channel above limit");
  dead_live_excl_a: assert property (!(LINE_DEENERGISED && LINE_LIVE))
    else $error("dead and live together");
  live_volts_a: assert property (LINE_LIVE |-> flg[2:0] == 3'h7)
    else $error("live line without all voltage flags");
  off_quiet_a: assert property (!en_r |=> outs == 8'h00)
    else $error("output active while switched off");
  inhibit_quiet_a: assert property (FUNCTION_INHIBIT_IN |=> outs == 8'h00)
    else $error("output active while inhibited");
  rise_gated_a: assert property (($rose(LINE_LIVE) || $rose(LINE_DEENERGISED))
    |-> $past(en_r) && !$past(FUNCTION_INHIBIT_IN)) else $error("line state rose while gated");
  vthr_range_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == `LSD_ADR_VTHR
    |-> WB_DAT_O >= 32'h0A && WB_DAT_O <= 32'h64) else $error("voltage setting out of range");
  ithr_range_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == `LSD_ADR_ITHR
    |-> WB_DAT_O >= 32'h02 && WB_DAT_O <= 32'h64) else $error("current setting out of range");
  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus answer not a single cycle after request");
endmodule
bind lsd_top lsd_properties u_props (
  .MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .FUNCTION_INHIBIT_IN(FUNCTION_INHIBIT_IN),
  .PHASE1_VOLT_OVER_LIMIT(PHASE1_VOLT_OVER_LIMIT), .PHASE2_VOLT_OVER_LIMIT(PHASE2_VOLT_OVER_LIMIT),
  .PHASE3_VOLT_OVER_LIMIT(PHASE3_VOLT_OVER_LIMIT), .PHASE1_CURR_OVER_LIMIT(PHASE1_CURR_OVER_LIMIT),
  .PHASE2_CURR_OVER_LIMIT(PHASE2_CURR_OVER_LIMIT), .PHASE3_CURR_OVER_LIMIT(PHASE3_CURR_OVER_LIMIT),
  .LINE_DEENERGISED(LINE_DEENERGISED), .LINE_LIVE(LINE_LIVE));

// file: sim/lsd_meas_model.sv
// Purpose: Behavioural source of six sampled line channels.
// Assumes: Sixteen samples per fundamental period.
// Notes:   Sample lines are scrambled between strobes.
`timescale 1ns/1ps
module lsd_meas_model (
  input  wire logic               clk,      // Clock.
  input  wire logic               rst_n,    // Reset, low.
  input  wire logic        [15:0] amp [6],  // Peak per channel.
  input  wire logic               slow,     // Spread the strobes.
  output logic                    stb,      // Sample strobe.
  output logic signed      [15:0] smp [6]   // Sample values.
);
  // ************************************************
  // Sample generation
  // ************************************************
  logic [3:0] ph_r;
  logic [2:0] gap_r;

  // One sine point of the given peak at step k of sixteen.
  function automatic logic signed [15:0] wave(input logic [15:0] a, input logic [3:0] k);
    return 16'($rtoi($itor(a) * $sin(6.2831853 * k / 16.0)));
  endfunction

  // Strobes back to back or every sixth cycle; lines carry noise in between.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      stb   <= 1'b0;
      ph_r  <= 4'h0;
      gap_r <= 3'h0;
      smp   <= '{default: 16'h0000};
    end
    else if (gap_r == 3'h0)
    begin
      stb   <= 1'b1;
      ph_r  <= ph_r + 4'h1;
      gap_r <= slow ? 3'h5 : 3'h0;
      foreach (smp[c])
        smp[c] <= wave(amp[c], ph_r);
    end
    else
    begin
      stb   <= 1'b0;
      gap_r <= gap_r - 3'h1;
      foreach (smp[c])
        smp[c] <= ~smp[c];
    end
endmodule

// file: sim/tb.sv
// Purpose: Self-checking bench of the line state detector.
// Assumes: Nominals at their defaults unless a test writes them.
// Notes:   Amplitudes keep wide margins from every threshold.
`timescale 1ns/1ps
`include "lsd_regs.svh"
module tb;
  // ************************************************
  // Signals, instances and tasks
  // ************************************************
  logic              mclk, rst_n, cyc, stb, we, inh, slow;
  logic [7:0]        adr;
  logic [3:0]        sel;
  logic [31:0]       wdat;
  logic [15:0]       amp [6];
  wire  [31:0]       dato;
  wire  [5:0]        flg;
  wire               ack, sstb, dead, live;
  wire signed [15:0] smp [6];
  int                num_errors, n_tests;
  localparam logic [5:0] PT [9] = '{6'h00, 6'h07, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20,
                                    6'h3F};
  localparam logic [6:0] WV [4] = '{7'h09, 7'h65, 7'h0A, 7'h3C};
  localparam logic [6:0] EV [4] = '{7'h0A, 7'h64, 7'h0A, 7'h3C};
  localparam logic [6:0] WI [4] = '{7'h01, 7'h7F, 7'h02, 7'h0A};
  localparam logic [6:0] EI [4] = '{7'h02, 7'h64, 7'h02, 7'h0A};

  lsd_meas_model src (.clk(mclk), .rst_n(rst_n), .amp(amp), .slow(slow), .stb(sstb), .smp(smp));
  lsd_top dut (
    .MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack), .SMP_STB(sstb),
    .SMP_VOLT1(smp[0]), .SMP_VOLT2(smp[1]), .SMP_VOLT3(smp[2]), .SMP_CURR1(smp[3]),
    .SMP_CURR2(smp[4]), .SMP_CURR3(smp[5]), .FUNCTION_INHIBIT_IN(inh),
    .PHASE1_VOLT_OVER_LIMIT(flg[0]), .PHASE2_VOLT_OVER_LIMIT(flg[1]),
    .PHASE3_VOLT_OVER_LIMIT(flg[2]), .PHASE1_CURR_OVER_LIMIT(flg[3]),
    .PHASE2_CURR_OVER_LIMIT(flg[4]), .PHASE3_CURR_OVER_LIMIT(flg[5]),
    .LINE_DEENERGISED(dead), .LINE_LIVE(live));

  // Compares and counts one value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic bus cycle, held until the acknowledge is sampled.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    // No limit of its own: only the watchdog ends a hang.
    @(posedge mclk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
    do
    begin
      @(posedge mclk);
    end
    while (ack !== 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Pattern bit set means that channel sits well above its limit.
  task automatic apply(input logic [5:0] p);
    foreach (amp[c])
      amp[c] <= c < 3 ? (p[c] ? 16'h3E80 : 16'h07D0) : (p[c] ? 16'h1F40 : 16'h01F4);
  endtask

  // Waits for two full windows plus the two register stages.
  task automatic settle();
    repeat (33) @(posedge mclk iff sstb === 1'b1);
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic outs(input logic [7:0] e);
    chk({24'h0, live, dead, flg}, {24'h0, e});
  endtask

  task automatic final_report();
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ************************************************
  // Clock, watchdog and test sequence
  // ************************************************
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    final_report();
  end

  initial
  begin
    logic [31:0] q;
    {rst_n, cyc, stb, we, inh, slow, adr, sel, wdat} = '0;
    num_errors = 0;
    n_tests = 0;
    foreach (amp[c])
      amp[c] = 16'h3E80 - 16'h07D0 * 16'(c);
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values, an unmapped place, and silence while switched off.
    rdc(`LSD_ADR_CTRL, 32'h0);
    rdc(`LSD_ADR_VTHR, 32'h3C);
    rdc(`LSD_ADR_ITHR, 32'h0A);
    rdc(8'h18, 32'h0);
    settle();
    outs(8'h00);
    // Each channel measured on its own amplitude.
    for (int c = 0; c < 6; c++)
    begin
      wb(1'b0, 8'(`LSD_ADR_MAG0 + 4 * c), 32'h0, q);
      chk(32'(q >= amp[c] - amp[c] / 8 && q <= amp[c] + amp[c] / 8), 32'h1);
    end
    // Setting limits beyond both ends and at the lower end, ending on the defaults.
    for (int k = 0; k < 4; k++)
    begin
      wr(`LSD_ADR_VTHR, {25'h0, WV[k]});
      rdc(`LSD_ADR_VTHR, {25'h0, EV[k]});
      wr(`LSD_ADR_ITHR, {25'h0, WI[k]});
      rdc(`LSD_ADR_ITHR, {25'h0, EI[k]});
    end
    // Every phase alone, all quiet and all up, strobes prompt and slow.
    wr(`LSD_ADR_CTRL, 32'h1);
    for (int k = 0; k < 9; k++)
    begin
      apply(PT[k]);
      slow <= k[0];
      settle();
      outs({PT[k][2:0] == 3'h7, PT[k] == 6'h00, PT[k]});
    end
    // Voltages near half of nominal: the setting and the nominal decide.
    apply(6'h00);
    for (int c = 0; c < 3; c++)
      amp[c] <= 16'h2134;
    settle();
    outs(8'h40);
    wr(`LSD_ADR_VTHR, 32'h2D);
    settle();
    outs(8'h87);
    wr(`LSD_ADR_VTHR, 32'h3C);
    wr(`LSD_ADR_VNOM, 32'h2000);
    settle();
    outs(8'h87);
    wr(`LSD_ADR_INOM, 32'h0400);
    settle();
    outs(8'hBF);
    rdc(`LSD_ADR_STAT, 32'h1FE);
    // Block input clears everything one edge later, and lets go again.
    @(posedge mclk);
    inh <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    outs(8'h00);
    wb(1'b0, `LSD_ADR_STAT, 32'h0, q);
    chk(q & 32'h300, 32'h200);
    inh <= 1'b0;
    settle();
    outs(8'hBF);
    wr(`LSD_ADR_CTRL, 32'h0);
    settle();
    outs(8'h00);
    final_report();
  end
endmodule
